// file: logic/uoc_map.vh
// Register map, field positions, reset values and codes of the endpoint controller
`ifndef UOC_MAP_VH
`define UOC_MAP_VH
// ==========================================
// Register offsets
`define UOC_A_INDEX 8'h0e
`define UOC_A_IN_HI 8'h12
`define UOC_A_OUT_LO 8'h14
`define UOC_A_OUT_HI 8'h15
`define UOC_A_CNT_LO 8'h16
`define UOC_A_CNT_HI 8'h17
`define UOC_A_IRQ_STAT 8'h20
`define UOC_A_IRQ_MASK 8'h21
// ==========================================
// IN control high byte fields
`define UOC_IH_DBL 7
`define UOC_IH_ISO 6
`define UOC_IH_DIR 5
`define UOC_IH_FORCE_TOGGLE_SWITCH 3
`define UOC_IH_SPLIT 2
`define UOC_IH_WMASK 8'hec
// ==========================================
// OUT control low and high byte fields
`define UOC_OL_CLRDT 7
`define UOC_OL_STALL_SENT_FLAG 6
`define UOC_OL_SEND_STALL_REQUEST 5
`define UOC_OL_FLUSH 4
`define UOC_OL_DERR 3
`define UOC_OL_OVR 2
`define UOC_OL_FULL 1
`define UOC_OL_OPR 0
`define UOC_OH_DBL 7
`define UOC_OH_ISO 6
`define UOC_OH_WMASK 8'hc0
// ==========================================
// Reset values and handshake codes
`define UOC_RST_BYTE 8'h00
`define UOC_RST_MASK 3'h7
`define UOC_HS_ACK 2'h0
`define UOC_HS_NAK 2'h1
`define UOC_HS_STALL 2'h2
`define UOC_LEN_W 10
`endif

// file: logic/uoc_len_mem.v
// Byte-count memory: two packet slots for each of the three OUT endpoints
`timescale 1ns/1ps
module uoc_len_mem (
  // Clock
  input wire clk_sys,
  // Write port
  input wire wr_en,
  input wire [2:0] wr_addr,
  input wire [9:0] wr_data,
  // Registered read port
  input wire [2:0] rd_addr,
  output reg [9:0] rd_data_r
);
  reg [9:0] mem [0:7];

  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end
endmodule

// file: logic/uoc_irq.v
// Sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/1ps
`include "uoc_map.vh"
module uoc_irq (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Events and register writes
  input wire [2:0] event_in,
  input wire wr_stat,
  input wire wr_mask,
  input wire [2:0] wdata,
  // State
  output reg [2:0] stat_r,
  output reg [2:0] mask_r,
  output reg irq_r
);
  reg [2:0] stat_nxt;
  reg [2:0] mask_nxt;

  always @* begin
    // Event set wins over a clear in the same cycle
    stat_nxt = (stat_r & ~(wr_stat ? wdata : 3'h0)) | event_in;
    mask_nxt = wr_mask ? wdata : mask_r;
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      stat_r <= 3'h0;
      mask_r <= `UOC_RST_MASK;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end
endmodule

// file: logic/uoc_ctrl.v
// Endpoint 1-3 controller: IN high control byte and OUT receive handling
//
// Contract
// R1: IN double-buffer enable bit turns IN FIFO double buffering on or off.
// R2: Split set gives upper FIFO half to IN, lower half to OUT.
// R3: Two low bits of IN control high read zero, writes ignored.
// R4: OUT endpoints do bulk, interrupt, isochronous; bulk and interrupt identical.
// R5: OUT isochronous select bit picks isochronous, else bulk/interrupt mode.
// R6: OUT interrupt on packet-ready set and on every stall.
// R7: Bulk OUT token plus data sets packet-ready and interrupts.
// R8: Count registers show byte count of the packet awaiting unload.
// R9: Firmware unloads packet then writes zero to packet-ready.
// R10: Send-stall set answers every bulk OUT with STALL.
// R11: Each STALL sets stall-sent and interrupts; firmware clears by writing zero.
// R12: Second buffered packet re-sets packet-ready after clear, second interrupt.
// R13: Firmware should double buffer isochronous OUT endpoints.
// R14: Isochronous packet is stored, packet-ready set, interrupt if enabled.
// R15: Isochronous packet with no room sets overrun and interrupts.
// R16: Isochronous CRC-bad packet stored, packet-ready set, data-error set.
// R17: Firmware checks data-error on each isochronous unload.
// R18: Unsplit FIFO direction follows direction select; ignored when split.
// R19: Force-toggle off flips IN toggle on ACK; on flips every packet.
`timescale 1ns/1ps
`include "uoc_map.vh"
module uoc_ctrl (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_r,
  // OUT packet events from the packet engine
  input wire out_done,
  input wire [1:0] out_ep,
  input wire [9:0] out_len,
  input wire out_crc_err,
  // Handshake decision for the packet engine
  output reg hs_valid_r,
  output reg hs_send_r,
  output reg [1:0] hs_code_r,
  // IN transmit events
  input wire in_sent,
  input wire in_acked,
  input wire [1:0] in_ep,
  // Data toggles, one bit per endpoint 1-3
  output reg [2:0] in_toggle_r,
  output reg [2:0] out_toggle_r,
  // FIFO configuration for the storage
  output reg [2:0] in_dbl_en_r,
  output reg [5:0] fifo_in_owns_r,
  output reg [2:0] out_ready_r,
  // Interrupt
  output wire usb_irq
);
  // ==========================================
  // Helpers
  function ep_ok;
    input [1:0] n;
    begin
      ep_ok = (n != 2'h0);
    end
  endfunction

  function [1:0] ep_idx;
    input [1:0] n;
    begin
      ep_idx = n - 2'h1;
    end
  endfunction

  // ==========================================
  // State
  reg [1:0] index_r;
  reg [7:0] in_hi_r [0:2];
  reg [7:0] out_hi_r [0:2];
  reg [2:0] opr_r;
  reg [2:0] rearm_r;
  reg [2:0] send_stall_request_r;
  reg [2:0] stall_sent_flag_r;
  reg [2:0] ovr_r;
  reg [1:0] pend_r [0:2];
  reg [2:0] wr_ptr_r;
  reg [2:0] rd_ptr_r;
  reg [5:0] crc_r;
  // One loop index per process so that no variable has two drivers
  integer e;
  integer c;
  integer t;
  integer f;

  wire [2:0] irq_stat;
  wire [2:0] irq_mask;
  wire [9:0] head_len;

  // ==========================================
  // Decode of the register port
  wire sel_ok = ep_ok(index_r);
  wire [1:0] sel = ep_idx(index_r);
  wire wr_in_hi = reg_wr && sel_ok && (reg_addr == `UOC_A_IN_HI);
  wire wr_out_lo = reg_wr && sel_ok && (reg_addr == `UOC_A_OUT_LO);
  wire wr_out_hi = reg_wr && sel_ok && (reg_addr == `UOC_A_OUT_HI);
  wire wr_stat = reg_wr && (reg_addr == `UOC_A_IRQ_STAT);
  wire wr_mask = reg_wr && (reg_addr == `UOC_A_IRQ_MASK);
  wire rx_ok = out_done && ep_ok(out_ep);
  wire [1:0] rx_ep = ep_idx(out_ep);

  // ==========================================
  // Per-endpoint receive decisions
  reg [2:0] acc_v;
  reg [2:0] iso_v;
  reg [2:0] room_v;
  reg [2:0] store_v;
  reg [2:0] stall_v;
  reg [2:0] ovr_v;
  reg [2:0] unl_v;
  reg [2:0] event_v;
  reg [1:0] cap;

  always @* begin
    acc_v = 3'h0;
    iso_v = 3'h0;
    room_v = 3'h0;
    store_v = 3'h0;
    stall_v = 3'h0;
    ovr_v = 3'h0;
    unl_v = 3'h0;
    event_v = 3'h0;
    cap = 2'h1;
    for (c = 0; c < 3; c = c + 1) begin
      acc_v[c] = rx_ok && (rx_ep == c[1:0]);
      iso_v[c] = out_hi_r[c][`UOC_OH_ISO]; // R4 R5
      cap = out_hi_r[c][`UOC_OH_DBL] ? 2'h2 : 2'h1;
      room_v[c] = (pend_r[c] < cap);
      if (iso_v[c]) begin
        // Isochronous: CRC-bad data is kept and flagged
        store_v[c] = acc_v[c] && room_v[c]; // R14 R16
        ovr_v[c] = acc_v[c] && !room_v[c]; // R15
      end else begin
        // Bulk and interrupt share this path; CRC-bad data is dropped
        stall_v[c] = acc_v[c] && send_stall_request_r[c]; // R10
        store_v[c] = acc_v[c] && !send_stall_request_r[c] && room_v[c] && !out_crc_err; // R7
      end
      // Clearing packet-ready or flushing retires the head packet
      unl_v[c] = wr_out_lo && (sel == c[1:0]) && opr_r[c] &&
                 (!reg_wdata[`UOC_OL_OPR] || reg_wdata[`UOC_OL_FLUSH]);
      event_v[c] = (!opr_r[c] && (store_v[c] || rearm_r[c])) || stall_v[c] || ovr_v[c]; // R6
    end
  end

  // ==========================================
  // Byte-count slots
  wire mem_we = |store_v;
  wire [2:0] mem_waddr = {rx_ep, wr_ptr_r[rx_ep]};
  wire [2:0] mem_raddr = {sel, rd_ptr_r[sel]};

  uoc_len_mem u_len_mem (
    .clk_sys(clk_sys),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(out_len),
    .rd_addr(mem_raddr),
    .rd_data_r(head_len)
  );

  // ==========================================
  // Interrupt status and mask
  uoc_irq u_irq (
    .clk_sys(clk_sys),
    .srst(srst),
    .event_in(event_v),
    .wr_stat(wr_stat),
    .wr_mask(wr_mask),
    .wdata(reg_wdata[2:0]),
    .stat_r(irq_stat),
    .mask_r(irq_mask),
    .irq_r(usb_irq)
  );

  // ==========================================
  // Endpoint state
  always @(posedge clk_sys) begin
    if (srst) begin
      index_r <= 2'h0;
      opr_r <= 3'h0;
      rearm_r <= 3'h0;
      send_stall_request_r <= 3'h0;
      stall_sent_flag_r <= 3'h0;
      ovr_r <= 3'h0;
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      crc_r <= 6'h00;
      for (e = 0; e < 3; e = e + 1) begin
        in_hi_r[e] <= `UOC_RST_BYTE;
        out_hi_r[e] <= `UOC_RST_BYTE;
        pend_r[e] <= 2'h0;
      end
    end else begin
      if (reg_wr && (reg_addr == `UOC_A_INDEX)) begin
        index_r <= reg_wdata[1:0];
      end
      for (e = 0; e < 3; e = e + 1) begin
        if (wr_in_hi && (sel == e[1:0])) begin
          in_hi_r[e] <= reg_wdata & `UOC_IH_WMASK; // R3
        end
        if (wr_out_hi && (sel == e[1:0])) begin
          out_hi_r[e] <= reg_wdata & `UOC_OH_WMASK; // R5
        end
        if (wr_out_lo && (sel == e[1:0])) begin
          send_stall_request_r[e] <= reg_wdata[`UOC_OL_SEND_STALL_REQUEST];
        end
        // Stall-sent: hardware set beats firmware's write of zero
        if (stall_v[e]) begin
          stall_sent_flag_r[e] <= 1'b1; // R11
        end else if (wr_out_lo && (sel == e[1:0]) && !reg_wdata[`UOC_OL_STALL_SENT_FLAG]) begin
          stall_sent_flag_r[e] <= 1'b0; // R11
        end
        if (ovr_v[e]) begin
          ovr_r[e] <= 1'b1; // R15
        end else if (wr_out_lo && (sel == e[1:0]) && !reg_wdata[`UOC_OL_OVR]) begin
          ovr_r[e] <= 1'b0;
        end
        pend_r[e] <= pend_r[e] + {1'b0, store_v[e]} - {1'b0, unl_v[e]};
        // Packet-ready drops for one cycle on unload, then returns if a
        // second packet waits, so firmware sees a fresh edge and interrupt
        rearm_r[e] <= unl_v[e] && ((pend_r[e] + {1'b0, store_v[e]}) > 2'h1); // R12
        if (unl_v[e]) begin
          opr_r[e] <= 1'b0; // R9
        end else if (store_v[e] || rearm_r[e]) begin
          opr_r[e] <= 1'b1; // R7 R14 R16
        end
        if (store_v[e]) begin
          wr_ptr_r[e] <= ~wr_ptr_r[e];
          crc_r[{e[1:0], wr_ptr_r[e]}] <= out_crc_err; // R16
        end
        if (unl_v[e]) begin
          rd_ptr_r[e] <= ~rd_ptr_r[e];
        end
      end
    end
  end

  // ==========================================
  // Data toggles
  always @(posedge clk_sys) begin
    if (srst) begin
      in_toggle_r <= 3'h0;
      out_toggle_r <= 3'h0;
    end else begin
      for (t = 0; t < 3; t = t + 1) begin
        if (ep_ok(in_ep) && (ep_idx(in_ep) == t[1:0])) begin
          if (in_hi_r[t][`UOC_IH_FORCE_TOGGLE_SWITCH] ? in_sent : in_acked) begin
            in_toggle_r[t] <= ~in_toggle_r[t]; // R19
          end
        end
        if (wr_out_lo && (sel == t[1:0]) && reg_wdata[`UOC_OL_CLRDT]) begin
          out_toggle_r[t] <= 1'b0;
        end else if (store_v[t] && !iso_v[t]) begin
          out_toggle_r[t] <= ~out_toggle_r[t];
        end
      end
    end
  end

  // ==========================================
  // Handshake toward the packet engine
  always @(posedge clk_sys) begin
    if (srst) begin
      hs_valid_r <= 1'b0;
      hs_send_r <= 1'b0;
      hs_code_r <= `UOC_HS_NAK;
    end else begin
      hs_valid_r <= rx_ok;
      // Isochronous traffic carries no handshake; bad CRC gets silence unless send-stall is set, which still sends STALL
      hs_send_r <= rx_ok && !iso_v[rx_ep] && (send_stall_request_r[rx_ep] || !out_crc_err);
      if (|stall_v) begin
        hs_code_r <= `UOC_HS_STALL; // R10
      end else if (|store_v) begin
        hs_code_r <= `UOC_HS_ACK;
      end else begin
        hs_code_r <= `UOC_HS_NAK;
      end
    end
  end

  // ==========================================
  // FIFO configuration
  always @(posedge clk_sys) begin
    if (srst) begin
      in_dbl_en_r <= 3'h0;
      fifo_in_owns_r <= 6'h00;
      out_ready_r <= 3'h0;
    end else begin
      out_ready_r <= opr_r;
      for (f = 0; f < 3; f = f + 1) begin
        in_dbl_en_r[f] <= in_hi_r[f][`UOC_IH_DBL]; // R1
        // Two bits per endpoint: IN owns upper half, IN owns lower half
        if (in_hi_r[f][`UOC_IH_SPLIT]) begin
          fifo_in_owns_r[2*f +: 2] <= 2'h2; // R2
        end else begin
          fifo_in_owns_r[2*f +: 2] <= {2{in_hi_r[f][`UOC_IH_DIR]}}; // R18
        end
      end
    end
  end

  // ==========================================
  // Read data, one cycle after the strobe
  always @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `UOC_A_INDEX: reg_rdata_r <= {6'h00, index_r};
        `UOC_A_IN_HI: reg_rdata_r <= sel_ok ? in_hi_r[sel] : 8'h00; // R3
        `UOC_A_OUT_HI: reg_rdata_r <= sel_ok ? out_hi_r[sel] : 8'h00;
        `UOC_A_OUT_LO: begin
          if (sel_ok) begin
            reg_rdata_r <= {1'b0, stall_sent_flag_r[sel], send_stall_request_r[sel], 1'b0,
                            opr_r[sel] & crc_r[{sel, rd_ptr_r[sel]}], ovr_r[sel],
                            ~room_v[sel], opr_r[sel]}; // R16
          end else begin
            reg_rdata_r <= 8'h00;
          end
        end
        // Count shows the head slot; zero when nothing waits
        `UOC_A_CNT_LO: begin
          reg_rdata_r <= (sel_ok && opr_r[sel]) ? head_len[7:0] : 8'h00; // R8
        end
        `UOC_A_CNT_HI: begin
          reg_rdata_r <= (sel_ok && opr_r[sel]) ? {6'h00, head_len[9:8]} : 8'h00; // R8
        end
        `UOC_A_IRQ_STAT: reg_rdata_r <= {5'h00, irq_stat};
        `UOC_A_IRQ_MASK: reg_rdata_r <= {5'h00, irq_mask};
        default: reg_rdata_r <= 8'h00;
      endcase
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end
endmodule

// file: test/uoc_ctrl_checker.sv
// Port-level assertions for the endpoint controller
`timescale 1ns/1ps
`include "uoc_map.vh"
module uoc_ctrl_checker (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_r,
  // Packet engine side
  input wire out_done,
  input wire [1:0] out_ep,
  input wire [9:0] out_len,
  input wire out_crc_err,
  input wire hs_valid_r,
  input wire hs_send_r,
  input wire [1:0] hs_code_r,
  input wire in_sent,
  input wire in_acked,
  input wire [1:0] in_ep,
  // State outputs
  input wire [2:0] in_toggle_r,
  input wire [2:0] out_toggle_r,
  input wire [2:0] in_dbl_en_r,
  input wire [5:0] fifo_in_owns_r,
  input wire [2:0] out_ready_r,
  input wire usb_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // ==========================================
  // Packet handling
  a_hs_after_done: assert property (
    out_done && out_ep != 2'h0 |=> hs_valid_r) else $error("no handshake decision after packet");
  a_stall_sent: assert property (
    hs_valid_r && hs_code_r == `UOC_HS_STALL |-> hs_send_r) else $error("stall not put on wire");
  a_ack_ready: assert property (
    hs_valid_r && hs_send_r && hs_code_r == `UOC_HS_ACK |=> out_ready_r != 3'h0)
    else $error("stored packet without ready flag");
  // A second buffered packet re-raises the event up to three edges after the clearing write
  a_irq_cause: assert property (
    $rose(usb_irq) |-> hs_valid_r || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("interrupt rose without cause");
  // ==========================================
  // IN control high byte
  a_toggle_cause: assert property (
    $changed(in_toggle_r) |-> $past(in_sent) || $past(in_acked)) else $error("toggle moved unprompted");
  a_dbl_cause: assert property (
    $changed(in_dbl_en_r) |-> $past(reg_wr) || $past(reg_wr, 2)) else $error("double buffer moved unprompted");
  a_owns_legal: assert property (
    fifo_in_owns_r[1:0] != 2'b01 && fifo_in_owns_r[3:2] != 2'b01 && fifo_in_owns_r[5:4] != 2'b01)
    else $error("IN owns lower half only");
  a_owns_cause: assert property (
    $changed(fifo_in_owns_r) |-> $past(reg_wr) || $past(reg_wr, 2)) else $error("FIFO split moved unprompted");
  a_in_lowbits: assert property (
    $past(reg_rd) && $past(reg_addr) == `UOC_A_IN_HI |-> reg_rdata_r[1:0] == 2'h0)
    else $error("unused IN bits read nonzero");
endmodule
bind uoc_ctrl uoc_ctrl_checker uoc_ctrl_checker_inst (.*);

// file: test/uoc_host_model.sv
// Behavioural packet engine standing in for host traffic
`timescale 1ns/1ps
module uoc_host_model (
  // Clock
  input wire clk_sys,
  // Packet events towards the controller
  output reg out_done,
  output reg [1:0] out_ep,
  output reg [9:0] out_len,
  output reg out_crc_err,
  output reg in_sent,
  output reg in_acked,
  output reg [1:0] in_ep,
  // Handshake decision back
  input wire hs_valid_r,
  input wire hs_send_r,
  input wire [1:0] hs_code_r
);
  reg [2:0] seen;
  initial begin
    out_done = 1'b0;
    out_ep = 2'h0;
    out_len = 10'h000;
    out_crc_err = 1'b0;
    in_sent = 1'b0;
    in_acked = 1'b0;
    in_ep = 2'h0;
    seen = 3'h0;
  end
  // One data packet per call; fields turn to junk after so stale values are never trusted
  task send_out(input [1:0] ep, input [9:0] len, input crc);
    begin
      @(posedge clk_sys);
      out_done <= 1'b1;
      out_ep <= ep;
      out_len <= len;
      out_crc_err <= crc;
      @(posedge clk_sys);
      out_done <= 1'b0;
      out_ep <= ~ep;
      out_len <= ~len;
      out_crc_err <= ~crc;
      #1;
      seen = hs_valid_r ? {hs_send_r, hs_code_r} : 3'h7;
    end
  endtask
  task in_event(input [1:0] ep, input s, input a);
    begin
      @(posedge clk_sys);
      in_sent <= s;
      in_acked <= a;
      in_ep <= ep;
      @(posedge clk_sys);
      in_sent <= 1'b0;
      in_acked <= 1'b0;
      in_ep <= ~ep;
      #1;
    end
  endtask
endmodule

// file: test/uoc_ctrl_tb_top.sv
// Testbench for the endpoint controller
`timescale 1ns/1ps
module uoc_ctrl_tb_top;
  reg clk_sys;
  reg srst;
  reg [7:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  wire [7:0] reg_rdata_r;
  wire out_done, out_crc_err, hs_valid_r, hs_send_r, in_sent, in_acked, usb_irq;
  wire [1:0] out_ep, hs_code_r, in_ep;
  wire [9:0] out_len;
  wire [2:0] in_toggle_r, out_toggle_r, in_dbl_en_r, out_ready_r;
  wire [5:0] fifo_in_owns_r;
  integer miscompares, compares, e;
  uoc_ctrl uoc_ctrl_inst (.*);
  uoc_host_model uoc_host_model_inst (.*);
  // ==========================================
  // Access tasks
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      // Configuration outputs lag a write by two edges; let them settle
      @(posedge clk_sys);
      #1;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata_r, exp);
    end
  endtask
  task pkt(input [1:0] ep, input [9:0] len, input crc);
    uoc_host_model_inst.send_out(ep, len, crc);
  endtask
  task final_report;
    begin
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ==========================================
  // Clock, watchdog and tests
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    miscompares = miscompares + 1;
    final_report;
  end
  initial begin
    miscompares = 0;
    compares = 0;
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    wr(8'h0e, 8'h01);
    rdc(8'h12, 8'h00);
    wr(8'h12, 8'hff);
    rdc(8'h12, 8'hec);
    chk({5'h00, in_dbl_en_r}, 8'h01);
    chk({2'h0, fifo_in_owns_r}, 8'h02);
    wr(8'h12, 8'h20);
    chk({2'h0, fifo_in_owns_r}, 8'h03);
    chk({5'h00, in_dbl_en_r}, 8'h00);
    wr(8'h12, 8'h08);
    uoc_host_model_inst.in_event(2'h1, 1'b1, 1'b0);
    chk({5'h00, in_toggle_r}, 8'h01);
    wr(8'h12, 8'h00);
    chk({2'h0, fifo_in_owns_r}, 8'h00);
    uoc_host_model_inst.in_event(2'h1, 1'b1, 1'b0);
    chk({5'h00, in_toggle_r}, 8'h01);
    uoc_host_model_inst.in_event(2'h1, 1'b0, 1'b1);
    chk({5'h00, in_toggle_r}, 8'h00);
    // Bulk receive on every endpoint, count at a non-trivial high byte
    for (e = 1; e < 4; e = e + 1) begin
      wr(8'h0e, e[7:0]);
      pkt(e[1:0], 10'h2a5, 1'b0);
      chk({5'h00, uoc_host_model_inst.seen}, 8'h04);
      chk({7'h00, usb_irq}, 8'h01);
      rdc(8'h14, 8'h03);
      rdc(8'h16, 8'ha5);
      rdc(8'h17, 8'h02);
      rdc(8'h20, 8'h01 << (e - 1));
      wr(8'h20, 8'h07);
      wr(8'h14, 8'h00);
      rdc(8'h14, 8'h00);
    end
    wr(8'h0e, 8'h01);
    wr(8'h15, 8'h80);
    pkt(2'h1, 10'h003, 1'b0);
    pkt(2'h1, 10'h007, 1'b0);
    rdc(8'h14, 8'h03);
    rdc(8'h16, 8'h03);
    wr(8'h20, 8'h01);
    wr(8'h14, 8'h00);
    rdc(8'h14, 8'h01);
    rdc(8'h16, 8'h07);
    rdc(8'h20, 8'h01);
    wr(8'h14, 8'h00);
    wr(8'h20, 8'h01);
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h20);
    pkt(2'h1, 10'h004, 1'b0);
    chk({5'h00, uoc_host_model_inst.seen}, 8'h06);
    rdc(8'h14, 8'h60);
    rdc(8'h20, 8'h01);
    wr(8'h14, 8'h60);
    rdc(8'h14, 8'h60);
    wr(8'h14, 8'h20);
    rdc(8'h14, 8'h20);
    wr(8'h14, 8'h00);
    wr(8'h20, 8'h01);
    chk({5'h00, out_toggle_r}, 8'h07);
    wr(8'h14, 8'h80);
    chk({5'h00, out_toggle_r}, 8'h06);
    // Bulk packet with a bad CRC is dropped without a handshake
    pkt(2'h1, 10'h005, 1'b1);
    chk({5'h00, uoc_host_model_inst.seen}, 8'h01);
    rdc(8'h14, 8'h00);
    // Isochronous: bad CRC still stored, then overrun with one slot
    wr(8'h15, 8'h40);
    pkt(2'h1, 10'h009, 1'b1);
    chk({7'h00, uoc_host_model_inst.seen[2]}, 8'h00);
    rdc(8'h14, 8'h0b);
    rdc(8'h16, 8'h09);
    pkt(2'h1, 10'h002, 1'b0);
    rdc(8'h14, 8'h0f);
    wr(8'h20, 8'h01);
    wr(8'h21, 8'h00);
    wr(8'h14, 8'h00);
    rdc(8'h14, 8'h00);
    pkt(2'h1, 10'h001, 1'b0);
    chk({7'h00, usb_irq}, 8'h00);
    rdc(8'h20, 8'h01);
    wr(8'h21, 8'h07);
    rdc(8'h21, 8'h07);
    chk({7'h00, usb_irq}, 8'h01);
    wr(8'h14, 8'h10);
    rdc(8'h14, 8'h00);
    wr(8'h30, 8'hff);
    rdc(8'h30, 8'h00);
    final_report;
  end
endmodule
